// >>> csh_pkg.sv
// shared constants, types and helpers for the camera setting command host
// assumes a 50 MHz system clock and a byte-wide link to sibling framing logic
package csh_pkg;

   // command codes of the three settings
   localparam logic [7:0] CODE_AOI_LEN  = 8'hAB;
   localparam logic [7:0] CODE_RED_GAIN = 8'h80;
   localparam logic [7:0] CODE_RED_OFS  = 8'h84;

   // second header byte: direction flag on top, data length below
   localparam int         FLAG_POS   = 7;
   localparam logic       FLAG_READ  = 1'b1;
   localparam logic       FLAG_WRITE = 1'b0;
   localparam logic [6:0] DATA_LEN   = 7'h02;

   // legal value ranges
   localparam logic [15:0] AOI_LEN_MIN  = 16'h0001;
   localparam logic [15:0] AOI_LEN_MAX  = 16'h0832;
   localparam logic [15:0] RED_GAIN_MIN = 16'h0060;
   localparam logic [15:0] RED_GAIN_MAX = 16'h03FF;
   localparam logic [15:0] RED_OFS_MIN  = 16'h0000;
   localparam logic [15:0] RED_OFS_MAX  = 16'h00FF;

   // timing: wait for a read answer
   localparam int          CLK_PERIOD_NS = 20;
   localparam int          RSP_WAIT_NS   = 20000;
   localparam int          RSP_WAIT_W    = 10;
   localparam logic [9:0]  RSP_WAIT_LAST = 10'(RSP_WAIT_NS / CLK_PERIOD_NS - 1);

   typedef enum logic [1:0] {
      CSH_SEL_AOI_LEN  = 2'b00,
      CSH_SEL_RED_GAIN = 2'b01,
      CSH_SEL_RED_OFS  = 2'b10
   } csh_sel_t;

   typedef struct packed {
      csh_sel_t    sel;
      logic        is_read;
      logic [15:0] value;
   } csh_req_t;

   typedef struct packed {
      csh_sel_t    sel;
      logic [15:0] value;
   } csh_rsp_t;

   // command code of a setting
   function automatic logic [7:0] code_of(input csh_sel_t sel);
      unique case (sel)
         CSH_SEL_AOI_LEN:  code_of = CODE_AOI_LEN;
         CSH_SEL_RED_GAIN: code_of = CODE_RED_GAIN;
         CSH_SEL_RED_OFS:  code_of = CODE_RED_OFS;
         default:          code_of = 8'h00;
      endcase
   endfunction

   // value legal for the setting; unknown setting never legal
   function automatic logic in_range(input csh_sel_t sel, input logic [15:0] v);
      unique case (sel)
         CSH_SEL_AOI_LEN:  in_range = (v >= AOI_LEN_MIN) && (v <= AOI_LEN_MAX);
         CSH_SEL_RED_GAIN: in_range = (v >= RED_GAIN_MIN) && (v <= RED_GAIN_MAX);
         CSH_SEL_RED_OFS:  in_range = (v >= RED_OFS_MIN) && (v <= RED_OFS_MAX);
         default:          in_range = 1'b0;
      endcase
   endfunction

endpackage

// >>> csh_rsp_rx.sv
// read answer parser: code, flag/length, low byte, high byte
// assumes bytes arrive from same-clock framing logic, one per valid cycle
`timescale 1ns/1ps
`default_nettype none
module csh_rsp_rx (
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              armed,
   input  wire csh_pkg::csh_sel_t expect_sel,
   input  wire logic              rx_valid,
   input  wire logic [7:0]        rx_byte,
   output logic                   done,
   output csh_pkg::csh_rsp_t      rsp
);
   import csh_pkg::*;

   typedef enum logic [1:0] {
      R_CODE = 2'b00,
      R_FLAG = 2'b01,
      R_LO   = 2'b10,
      R_HI   = 2'b11
   } csh_rx_state_t;

   csh_rx_state_t state_q;
   logic [7:0]    lo_q;

   // walk the four answer bytes, resync on anything unexpected
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= R_CODE;
      end else if (!armed) begin
         state_q <= R_CODE;
      end else if (rx_valid) begin
         unique case (state_q)
            R_CODE: state_q <= (rx_byte == code_of(expect_sel)) ? R_FLAG : R_CODE;
            R_FLAG: state_q <= (rx_byte == {FLAG_WRITE, DATA_LEN}) ? R_LO : R_CODE;
            R_LO:   state_q <= R_HI;
            R_HI:   state_q <= R_CODE;
         endcase
      end
   end

   // low byte comes first
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lo_q <= 8'h00;
      end else if (armed && rx_valid && state_q == R_LO) begin
         lo_q <= rx_byte;
      end
   end

   // whole answer in: hand over the assembled value
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         done <= 1'b0;
         rsp  <= '0;
      end else begin
         done <= armed && rx_valid && state_q == R_HI;
         if (armed && rx_valid && state_q == R_HI) begin
            rsp.sel   <= expect_sel;
            rsp.value <= {rx_byte, lo_q};
         end
      end
   end

   property p_answer_pair;
      @(posedge clk) disable iff (rst)
      armed && rx_valid && state_q == R_HI |=> done && rsp.value == {$past(rx_byte), $past(lo_q)};
   endproperty
   a_answer_pair: assert property (p_answer_pair) else $error("answer value not high/low pair");

   property p_no_done_early;
      @(posedge clk) disable iff (rst)
      done |-> $past(state_q) == R_HI && $past(rx_valid);
   endproperty
   a_no_done_early: assert property (p_no_done_early) else $error("answer reported before last byte");

endmodule
`default_nettype wire

// >>> csh_cmd_host.sv
// host-side command sender for three camera settings
// assumes byte-wide tx/rx streams to framing logic on CLK_SYS
`timescale 1ns/1ps
`default_nettype none
// How it works
// - length setting uses code 0xAB, two bytes
// - length value sent low byte first
// - length value limited to 0x0001..0x0832
// - red gain uses code 0x80, two bytes
// - red gain sent low byte first
// - red gain limited to 0x0060..0x03FF
// - red offset uses code 0x84, two bytes
// - red offset sent low byte first
// - red offset limited to 0x0000..0x00FF
// - read flag 1 no data; write flag 0
module csh_cmd_host (
   input  wire logic              CLK_SYS,
   input  wire logic              RESET,
   input  wire logic              REQ_VALID,
   input  wire csh_pkg::csh_req_t REQ,
   output logic                   REQ_READY,
   output logic                   REQ_ERR,
   output logic                   TX_VALID,
   output logic [7:0]             TX_BYTE,
   input  wire logic              TX_READY,
   input  wire logic              RX_VALID,
   input  wire logic [7:0]        RX_BYTE,
   output logic                   RSP_VALID,
   output csh_pkg::csh_rsp_t      RSP,
   output logic                   RSP_TIMEOUT
);
   import csh_pkg::*;

   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_CODE = 3'b001,
      S_FLAG = 3'b010,
      S_DLO  = 3'b011,
      S_DHI  = 3'b100,
      S_WAIT = 3'b101
   } csh_state_t;

   csh_state_t             state_q;
   csh_req_t               req_q;
   logic [7:0]             tx_byte_q;
   logic [RSP_WAIT_W-1:0]  wait_q;
   logic                   accept;
   logic                   legal;
   logic                   rx_done;
   logic                   tx_step;

   // request checks: reads legal for any known setting, writes only in range
   assign legal     = REQ.is_read ? (code_of(REQ.sel) != 8'h00) : in_range(REQ.sel, REQ.value);
   assign REQ_READY = (state_q == S_IDLE);
   assign accept    = REQ_VALID && REQ_READY && legal;
   assign TX_VALID  = (state_q == S_CODE) || (state_q == S_FLAG) || (state_q == S_DLO) || (state_q == S_DHI);
   assign tx_step   = TX_VALID && TX_READY;
   assign TX_BYTE   = tx_byte_q;

   // command sequencer
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         state_q <= S_IDLE;
      end else begin
         unique case (state_q)
            S_IDLE: if (accept) state_q <= S_CODE;
            S_CODE: if (tx_step) state_q <= S_FLAG;
            S_FLAG: if (tx_step) state_q <= req_q.is_read ? S_WAIT : S_DLO;
            S_DLO:  if (tx_step) state_q <= S_DHI;
            S_DHI:  if (tx_step) state_q <= S_IDLE;
            S_WAIT: if (rx_done || wait_q == RSP_WAIT_LAST) state_q <= S_IDLE;
            default: state_q <= S_IDLE;
         endcase
      end
   end

   // request latch
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         req_q <= '0;
      end else if (accept) begin
         req_q <= REQ;
      end
   end

   // byte to present next: code, flag/length, low, high
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         tx_byte_q <= 8'h00;
      end else if (accept) begin
         tx_byte_q <= code_of(REQ.sel);
      end else if (tx_step) begin
         unique case (state_q)
            S_CODE: tx_byte_q <= {(req_q.is_read ? FLAG_READ : FLAG_WRITE), DATA_LEN};
            S_FLAG: tx_byte_q <= req_q.value[7:0];
            S_DLO:  tx_byte_q <= req_q.value[15:8];
            default: tx_byte_q <= 8'h00;
         endcase
      end
   end

   // answer timeout counter, only while waiting
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         wait_q <= '0;
      end else if (state_q == S_WAIT) begin
         wait_q <= wait_q + 1'b1;
      end else begin
         wait_q <= '0;
      end
   end

   // one-cycle status pulses
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         REQ_ERR     <= 1'b0;
         RSP_TIMEOUT <= 1'b0;
      end else begin
         REQ_ERR     <= REQ_VALID && REQ_READY && !legal;
         RSP_TIMEOUT <= (state_q == S_WAIT) && !rx_done && (wait_q == RSP_WAIT_LAST);
      end
   end

   // answer parsing
   csh_rsp_rx u_rx (
      .clk        (CLK_SYS),
      .rst        (RESET),
      .armed      (state_q == S_WAIT),
      .expect_sel (req_q.sel),
      .rx_valid   (RX_VALID),
      .rx_byte    (RX_BYTE),
      .done       (rx_done),
      .rsp        (RSP)
   );
   assign RSP_VALID = rx_done;

   property p_refuse_range;
      @(posedge CLK_SYS) disable iff (RESET)
      REQ_VALID && REQ_READY && !REQ.is_read && !in_range(REQ.sel, REQ.value) |=> REQ_ERR && state_q == S_IDLE;
   endproperty
   a_refuse_range: assert property (p_refuse_range) else $error("out of range write not refused");

   property p_code_first;
      @(posedge CLK_SYS) disable iff (RESET)
      accept |=> TX_VALID && state_q == S_CODE && TX_BYTE == code_of($past(REQ.sel));
   endproperty
   a_code_first: assert property (p_code_first) else $error("command code wrong or missing");

   property p_code_holds;
      @(posedge CLK_SYS) disable iff (RESET)
      state_q == S_CODE && !TX_READY |=> state_q == S_CODE && $stable(TX_BYTE);
   endproperty
   a_code_holds: assert property (p_code_holds) else $error("code byte dropped under back-pressure");

   property p_flag_byte;
      @(posedge CLK_SYS) disable iff (RESET)
      state_q == S_FLAG |-> TX_BYTE == {req_q.is_read, DATA_LEN};
   endproperty
   a_flag_byte: assert property (p_flag_byte) else $error("direction flag or length wrong");

   property p_read_no_data;
      @(posedge CLK_SYS) disable iff (RESET)
      state_q == S_FLAG && req_q.is_read && TX_READY |=> !TX_VALID && state_q == S_WAIT;
   endproperty
   a_read_no_data: assert property (p_read_no_data) else $error("read carried data bytes");

   property p_low_then_high;
      @(posedge CLK_SYS) disable iff (RESET)
      state_q == S_DLO && TX_READY
         |-> TX_BYTE == req_q.value[7:0] ##1 (state_q == S_DHI && TX_BYTE == req_q.value[15:8]);
   endproperty
   a_low_then_high: assert property (p_low_then_high) else $error("data bytes not low then high");

   property p_write_done;
      @(posedge CLK_SYS) disable iff (RESET)
      state_q == S_DHI && TX_READY |=> state_q == S_IDLE && !RSP_VALID;
   endproperty
   a_write_done: assert property (p_write_done) else $error("write did not end after high byte");

   property p_wait_bound;
      @(posedge CLK_SYS) disable iff (RESET)
      $rose(state_q == S_WAIT) |-> ##[1:1000] state_q != S_WAIT;
   endproperty
   a_wait_bound: assert property (p_wait_bound) else $error("answer wait not bounded");

   property p_offset_range;
      @(posedge CLK_SYS) disable iff (RESET)
      REQ_VALID && REQ_READY && !REQ.is_read && REQ.sel == CSH_SEL_RED_OFS && REQ.value > RED_OFS_MAX
         |=> REQ_ERR && !TX_VALID;
   endproperty
   a_offset_range: assert property (p_offset_range) else $error("offset write above limit accepted");

   property p_gain_range;
      @(posedge CLK_SYS) disable iff (RESET)
      REQ_VALID && REQ_READY && !REQ.is_read && REQ.sel == CSH_SEL_RED_GAIN && REQ.value < RED_GAIN_MIN
         |=> REQ_ERR && !TX_VALID;
   endproperty
   a_gain_range: assert property (p_gain_range) else $error("gain write below limit accepted");

   property p_code_byte_sel;
      @(posedge CLK_SYS) disable iff (RESET)
      state_q == S_CODE |-> TX_BYTE == code_of(req_q.sel);
   endproperty
   a_code_byte_sel: assert property (p_code_byte_sel) else $error("code byte does not match setting");

endmodule
`default_nettype wire

// >>> csh_dev_model.sv
// camera model: holds the three settings, answers reads
// assumes the host's byte stream on the same clock
`timescale 1ns/1ps
`default_nettype none
module csh_dev_model
   import csh_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_byte,
   input  wire logic       tx_ready,
   output logic            rx_valid,
   output logic [7:0]      rx_byte
);
   logic [7:0]  cmd [0:3];
   logic [7:0]  ans [0:3];
   logic [15:0] val [0:3];
   int          cnt, pend, dly, i;
   int          delay = 2;     // answer latency, bench may raise it
   logic        mute  = 1'b0;  // bench silences answers
   // legal value of a setting
   function automatic logic ok(input int k, input logic [15:0] v);
      return k == 0 ? (v >= 16'h0001 && v <= 16'h0832) :
             k == 1 ? (v >= 16'h0060 && v <= 16'h03FF) :
             (k == 2 && v <= 16'h00FF);
   endfunction
   // byte intake, settings and answers
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt = 0;
         pend = 0;
         val[0] = 16'h0832;
         val[1] = 16'h0060;
         val[2] = 16'h0000;
         rx_valid <= 1'b0;
         rx_byte  <= 8'h5A;
      end else begin
         rx_valid <= 1'b0;
         rx_byte  <= ~rx_byte;  // idle line keeps changing
         if (pend > 0 && dly > 0) dly--;
         else if (pend > 0) begin
            rx_valid <= 1'b1;
            rx_byte  <= ans[4-pend];
            pend--;
         end
         if (tx_valid && tx_ready) begin
            cmd[cnt] = tx_byte;
            cnt++;
            i = cmd[0] == 8'hAB ? 0 : cmd[0] == 8'h80 ? 1 : cmd[0] == 8'h84 ? 2 : 3;
            if (cnt == 2 && cmd[1] == 8'h82) begin
               ans[0] = cmd[0];
               ans[1] = 8'h02;
               ans[2] = val[i][7:0];
               ans[3] = val[i][15:8];
               pend = (mute || i == 3) ? 0 : 4;
               dly = delay;
               cnt = 0;
            end else if (cnt == 4) begin
               if (cmd[1] == 8'h02 && ok(i, {cmd[3], cmd[2]})) val[i] = {cmd[3], cmd[2]};
               cnt = 0;
            end
         end
      end
   end
endmodule
`default_nettype wire

// >>> tb.sv
// testbench for the setting command host against the camera model
// assumes csh_pkg, csh_cmd_host and csh_dev_model are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb;
   import csh_pkg::*;
   logic       CLK_SYS = 1'b0, RESET = 1'b1, REQ_VALID = 1'b0, TX_READY = 1'b1, stall = 1'b0;
   csh_req_t   REQ = '0;
   logic       REQ_READY, REQ_ERR, TX_VALID, RX_VALID, RSP_VALID, RSP_TIMEOUT;
   logic [7:0] TX_BYTE, RX_BYTE;
   csh_rsp_t   RSP;
   int         n_errors = 0, checks = 0, cyc = 0, n_rerr = 0, n_rsp = 0, n_tmo = 0;
   logic [7:0] tx_q [$];
   logic [7:0] code [0:2] = '{8'hAB, 8'h80, 8'h84};

   always #10 CLK_SYS = ~CLK_SYS;

   csh_cmd_host dut (.CLK_SYS(CLK_SYS), .RESET(RESET), .REQ_VALID(REQ_VALID), .REQ(REQ),
      .REQ_READY(REQ_READY), .REQ_ERR(REQ_ERR), .TX_VALID(TX_VALID), .TX_BYTE(TX_BYTE),
      .TX_READY(TX_READY), .RX_VALID(RX_VALID), .RX_BYTE(RX_BYTE), .RSP_VALID(RSP_VALID),
      .RSP(RSP), .RSP_TIMEOUT(RSP_TIMEOUT));
   csh_dev_model dev (.clk(CLK_SYS), .rst(RESET), .tx_valid(TX_VALID), .tx_byte(TX_BYTE),
      .tx_ready(TX_READY), .rx_valid(RX_VALID), .rx_byte(RX_BYTE));

   // capture sent bytes and output pulses, cut a hang short
   always @(posedge CLK_SYS) begin
      if (TX_VALID && TX_READY) tx_q.push_back(TX_BYTE);
      if (REQ_ERR) n_rerr++;
      if (RSP_VALID) n_rsp++;
      if (RSP_TIMEOUT) n_tmo++;
      cyc++;
      if (cyc == 5000) begin
         n_errors++;
         final_report();
      end
   end
   // framing side stalls every other cycle when asked
   always @(negedge CLK_SYS) TX_READY <= stall ? ~TX_READY : 1'b1;

   task automatic final_report();
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // present one request and wait for the host to finish it
   task automatic issue(input csh_sel_t s, input logic rd, input logic [15:0] v);
      int k;
      tx_q = {};
      REQ_VALID = 1'b1;
      REQ = '{s, rd, v};
      @(posedge CLK_SYS);
      @(negedge CLK_SYS);
      REQ_VALID = 1'b0;
      for (k = 0; k < 2000 && REQ_READY !== 1'b1; k++) @(negedge CLK_SYS);
      repeat (3) @(negedge CLK_SYS);
   endtask
   // write then read back one setting, checking both byte streams
   task automatic wr_rd(input csh_sel_t s, input logic [15:0] v);
      int r;
      issue(s, 1'b0, v);
      chk(16'(tx_q.size()), 16'd4);
      chk({tx_q[0], tx_q[1]}, {code[s], 8'h02});
      chk({tx_q[3], tx_q[2]}, v);
      chk(dev.val[s], v);
      r = n_rsp;
      issue(s, 1'b1, 16'h0000);
      chk(16'(tx_q.size()), 16'd2);
      chk({tx_q[0], tx_q[1]}, {code[s], 8'h82});
      chk(16'(n_rsp - r), 16'd1);
      chk(RSP.value, v);
      chk({14'h0, RSP.sel}, {14'h0, s});
   endtask
   // out-of-range write: one refusal pulse, nothing sent
   task automatic refuse(input csh_sel_t s, input logic [15:0] v);
      int e;
      e = n_rerr;
      issue(s, 1'b0, v);
      chk(16'(n_rerr - e), 16'd1);
      chk(16'(tx_q.size()), 16'd0);
   endtask
   // silent camera: host gives up with one timeout and no answer
   task automatic silent();
      int r, t;
      r = n_rsp;
      t = n_tmo;
      dev.mute = 1'b1;
      issue(CSH_SEL_RED_GAIN, 1'b1, 16'h0000);
      dev.mute = 1'b0;
      chk(16'(n_tmo - t), 16'd1);
      chk(16'(n_rsp - r), 16'd0);
   endtask

   // main sequence
   initial begin
      repeat (20) @(negedge CLK_SYS);
      RESET = 1'b0;
      @(negedge CLK_SYS);
      wr_rd(CSH_SEL_AOI_LEN, 16'h0001);
      wr_rd(CSH_SEL_AOI_LEN, 16'h0832);
      wr_rd(CSH_SEL_RED_GAIN, 16'h03FF);
      wr_rd(CSH_SEL_RED_GAIN, 16'h0060);
      wr_rd(CSH_SEL_RED_OFS, 16'h00FF);
      wr_rd(CSH_SEL_RED_OFS, 16'h0000);
      refuse(CSH_SEL_AOI_LEN, 16'h0000);
      refuse(CSH_SEL_AOI_LEN, 16'h0833);
      refuse(CSH_SEL_RED_GAIN, 16'h005F);
      refuse(CSH_SEL_RED_GAIN, 16'h0400);
      refuse(CSH_SEL_RED_OFS, 16'h0100);
      refuse(csh_sel_t'(2'b11), 16'h0010);
      stall = 1'b1;
      dev.delay = 40;
      wr_rd(CSH_SEL_RED_GAIN, 16'h0155);
      stall = 1'b0;
      dev.delay = 2;
      silent();
      final_report();
   end
endmodule
`default_nettype wire
